// ---- include/pscr_defines.svh ----
// Offsets, reset values, field positions and scale constants of the bank
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH

`define PSCR_OFS_OFFSET_STAGE   8'h10
`define PSCR_OFS_BIAS_STAGE     8'h11
`define PSCR_OFS_AUX_TRIM       8'h14
`define PSCR_OFS_SKIP           8'h16
`define PSCR_OFS_USER_CFG       8'h17
`define PSCR_OFS_OPEN_LOOP      8'h18

`define PSCR_RST_OFFSET_STAGE   8'hC0
`define PSCR_RST_BIAS_STAGE     8'h00
`define PSCR_RST_AUX_TRIM       8'h00
`define PSCR_RST_SKIP           8'h00
`define PSCR_RST_USER_CFG       8'h02
`define PSCR_RST_OPEN_LOOP      8'h00

`define PSCR_STAGE_MSB          7
`define PSCR_STAGE_LSB          5
`define PSCR_LEVEL_MSB          4
`define PSCR_LEVEL_LSB          0
`define PSCR_SKIP_MSB           4
`define PSCR_CLK_RANGE_BIT      7
`define PSCR_LIMIT_BIT          5
`define PSCR_LIGHT_MSB          3
`define PSCR_OLV_MSB            7
`define PSCR_OLV_LSB            4
`define PSCR_USER_WR_MASK       8'hAF

`define PSCR_TRIM_BASE_MV       32'd1000
`define PSCR_TRIM_STEP_CMV      32'd1569
`define PSCR_TRIM_STEP_DIV      32'd100
`define PSCR_OLV_BASE_V         5'h03

`endif

// ---- include/pscr_pkg.sv ----
// Types shared by the sequencing and configuration register bank
package pscr_pkg;

  typedef enum logic [2:0] {
    PSCR_LIGHT_OFF       = 3'b000,
    PSCR_LIGHT_DUAL_3A   = 3'b001,
    PSCR_LIGHT_SINGLE_6A = 3'b010,
    PSCR_LIGHT_SINGLE_3A = 3'b011,
    PSCR_LIGHT_EXTERNAL  = 3'b100
  } pscr_light_mode_type;

  // Bit order matches the skip register, bit 4 down to bit 0
  typedef struct packed {
    logic aux_converter_three;
    logic aux_converter_one;
    logic aux_converter_two;
    logic mirror_supply_converter_one;
    logic mirror_supply_converter_two;
  } pscr_skip_type;

  typedef struct packed {
    logic [8:0]          offset_rail_stage_time_ms;
    logic [8:0]          bias_rail_stage_time_ms;
    logic                bias_rail_stage_skip;
    logic [4:0]          battery_warning_threshold_code;
    logic [10:0]         battery_warning_threshold_cv;
    logic [4:0]          lockout_threshold_code;
    logic [10:0]         lockout_threshold_cv;
    logic [7:0]          aux_converter_two_trim;
    logic [12:0]         aux_converter_two_mv;
    pscr_skip_type       skip_enable;
    logic                serial_clock_range_select;
    logic                external_lowside_limit_enable;
    pscr_light_mode_type light_mode;
    logic [3:0]          light_open_loop_voltage_code;
    logic [4:0]          light_open_loop_voltage_v;
  } pscr_ctrl_type;

  typedef struct packed {
    logic [7:0]    offset_stage;
    logic [7:0]    bias_stage;
    logic [7:0]    aux_trim;
    logic [7:0]    skip;
    logic [7:0]    user_cfg;
    logic [7:0]    open_loop;
    logic [7:0]    rdata;
    logic          rvalid;
    pscr_ctrl_type ctrl;
  } pscr_state_type;

endpackage : pscr_pkg

// ---- src/pscr_config_regs.sv ----
// Sequencing, threshold, trim and user configuration register bank
`timescale 1ns/100ps
`include "pscr_defines.svh"

// Notes on behaviour
// RL1 - Offset-rail stage field bits 7:5 picks 1,5,10,20,40,80,160,320 ms.
// RL2 - Bias-rail stage code 0 skips the stage; others give 5 to 320 ms.
// RL3 - Offset register bits 4:0 pick one of 32 battery warning levels.
// RL4 - Bias register bits 4:0 pick lockout level from the same table.
// RL5 - Aux buck two output is 1 V plus code times 15.69 mV.
// RL6 - Skip bits 4..0 enable skip for aux three, one, two, mirror one, two.
// RL7 - Skip register bits 7:5 are ignored on write.
// RL8 - User bit 7 selects serial clock range; host keeps its clock inside.
// RL9 - User bit 5 enables external low-side switch current limiting.
// RL10 - Light config is upper source bit above user bits 3:0.
// RL11 - Upper bit set: xx00 off, x110 dual, 0010 single 6A, 1010 single 3A.
// RL12 - Upper bit clear: lowest bit set external, else same decode by bits 3:1.
// RL13 - Open-loop voltage field bits 7:4 gives 3 V plus code volts.
// RL14 - Offset stage register at 0x10, read-write, resets to 0xC0.
// RL15 - Every register resets to its value and holds writes until next write.
// RL16 - Reserved bits read zero and writes to them change nothing; open-loop register bits 3:0 are stored and read back as written.
module pscr_config_regs
  import pscr_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  input  wire logic [7:0]    REG_WDATA,
  output logic      [7:0]    REG_RDATA,
  output logic               REG_RVALID,
  input  wire logic          LIGHT_CFG_UPPER_SOURCE,
  output pscr_ctrl_type      CTRL
);

  localparam logic [10:0] LEVEL_CV [32] = '{
    11'h189, 11'h250, 11'h26D, 11'h278, 11'h283, 11'h28F, 11'h29B, 11'h2B5,
    11'h2D7, 11'h2E7, 11'h31B, 11'h34E, 11'h37D, 11'h3B3, 11'h3E0, 11'h412,
    11'h446, 11'h47A, 11'h4A8, 11'h4DA, 11'h511, 11'h53E, 11'h56F, 11'h5A3,
    11'h5D8, 11'h60B, 11'h637, 11'h665, 11'h697, 11'h6CC, 11'h704, 11'h731};

  localparam logic [8:0] STAGE_MS [8] = '{
    9'h001, 9'h005, 9'h00A, 9'h014, 9'h028, 9'h050, 9'h0A0, 9'h140};

  // Shared by both threshold selections
  function automatic logic [10:0] level_cv(input logic [4:0] code);
    level_cv = LEVEL_CV[code];
  endfunction : level_cv

  function automatic logic [12:0] trim_mv(input logic [7:0] code);
    logic [31:0] prod;
    prod = `PSCR_TRIM_BASE_MV + (32'(code) * `PSCR_TRIM_STEP_CMV) / `PSCR_TRIM_STEP_DIV;
    trim_mv = prod[12:0];
  endfunction : trim_mv

  // Codes with upper bit set and lowest bit set are undefined; held off
  function automatic pscr_light_mode_type light_decode(
    input logic       upper,
    input logic [3:0] low
  );
    light_decode = PSCR_LIGHT_OFF;
    if (!upper && low[0]) begin
      light_decode = PSCR_LIGHT_EXTERNAL; // [RL12]
    end else if (!low[0] && low[1]) begin
      if (low[2]) begin
        light_decode = PSCR_LIGHT_DUAL_3A; // [RL11] [RL12]
      end else if (low[3]) begin
        light_decode = PSCR_LIGHT_SINGLE_3A; // [RL11] [RL12]
      end else begin
        light_decode = PSCR_LIGHT_SINGLE_6A; // [RL11] [RL12]
      end
    end
  endfunction : light_decode

  function automatic pscr_ctrl_type decode(
    input pscr_state_type s,
    input logic           upper
  );
    logic [2:0] bias_code;
    bias_code = s.bias_stage[`PSCR_STAGE_MSB:`PSCR_STAGE_LSB];
    decode = '0;
    decode.offset_rail_stage_time_ms =
      STAGE_MS[s.offset_stage[`PSCR_STAGE_MSB:`PSCR_STAGE_LSB]]; // [RL1]
    decode.bias_rail_stage_skip = (bias_code == 3'h0); // [RL2]
    decode.bias_rail_stage_time_ms =
      (bias_code == 3'h0) ? 9'h000 : STAGE_MS[bias_code]; // [RL2]
    decode.battery_warning_threshold_code =
      s.offset_stage[`PSCR_LEVEL_MSB:`PSCR_LEVEL_LSB];
    decode.battery_warning_threshold_cv =
      level_cv(s.offset_stage[`PSCR_LEVEL_MSB:`PSCR_LEVEL_LSB]); // [RL3]
    decode.lockout_threshold_code =
      s.bias_stage[`PSCR_LEVEL_MSB:`PSCR_LEVEL_LSB];
    decode.lockout_threshold_cv =
      level_cv(s.bias_stage[`PSCR_LEVEL_MSB:`PSCR_LEVEL_LSB]); // [RL4]
    decode.aux_converter_two_trim = s.aux_trim;
    decode.aux_converter_two_mv = trim_mv(s.aux_trim); // [RL5]
    decode.skip_enable = s.skip[`PSCR_SKIP_MSB:0]; // [RL6]
    decode.serial_clock_range_select = s.user_cfg[`PSCR_CLK_RANGE_BIT]; // [RL8]
    decode.external_lowside_limit_enable = s.user_cfg[`PSCR_LIMIT_BIT]; // [RL9]
    decode.light_mode =
      light_decode(upper, s.user_cfg[`PSCR_LIGHT_MSB:0]); // [RL10]
    decode.light_open_loop_voltage_code =
      s.open_loop[`PSCR_OLV_MSB:`PSCR_OLV_LSB];
    decode.light_open_loop_voltage_v = `PSCR_OLV_BASE_V +
      5'(s.open_loop[`PSCR_OLV_MSB:`PSCR_OLV_LSB]); // [RL13]
  endfunction : decode

  // Reset image; control outputs are the decode of it with upper bit clear
  function automatic pscr_state_type reset_image();
    pscr_state_type img;
    img = '0;
    img.offset_stage = `PSCR_RST_OFFSET_STAGE; // [RL14] [RL15]
    img.bias_stage = `PSCR_RST_BIAS_STAGE; // [RL15]
    img.aux_trim = `PSCR_RST_AUX_TRIM; // [RL15]
    img.skip = `PSCR_RST_SKIP; // [RL15]
    img.user_cfg = `PSCR_RST_USER_CFG; // [RL15]
    img.open_loop = `PSCR_RST_OPEN_LOOP; // [RL15]
    img.ctrl = decode(img, 1'b0);
    reset_image = img;
  endfunction : reset_image

  // Constant image keeps the asynchronous reset branch free of logic
  localparam pscr_state_type STATE_RST = reset_image();

  pscr_state_type state_reg;
  pscr_state_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = REG_RD;
    if (REG_RD) begin
      // Read returns the value held before a same-cycle write
      case (REG_ADDR)
        `PSCR_OFS_OFFSET_STAGE: state_next.rdata = state_reg.offset_stage;
        `PSCR_OFS_BIAS_STAGE:   state_next.rdata = state_reg.bias_stage;
        `PSCR_OFS_AUX_TRIM:     state_next.rdata = state_reg.aux_trim;
        `PSCR_OFS_SKIP:         state_next.rdata = state_reg.skip;
        `PSCR_OFS_USER_CFG:     state_next.rdata = state_reg.user_cfg;
        `PSCR_OFS_OPEN_LOOP:    state_next.rdata = state_reg.open_loop;
        default:                state_next.rdata = 8'h00;
      endcase
    end
    if (REG_WR) begin
      case (REG_ADDR)
        `PSCR_OFS_OFFSET_STAGE: state_next.offset_stage = REG_WDATA; // [RL14] [RL15]
        `PSCR_OFS_BIAS_STAGE:   state_next.bias_stage = REG_WDATA; // [RL15]
        `PSCR_OFS_AUX_TRIM:     state_next.aux_trim = REG_WDATA; // [RL15]
        `PSCR_OFS_SKIP: begin
          // Upper bits dropped so they never steer and always read zero
          state_next.skip = {3'h0, REG_WDATA[`PSCR_SKIP_MSB:0]}; // [RL7] [RL16]
        end
        `PSCR_OFS_USER_CFG: begin
          state_next.user_cfg = REG_WDATA & `PSCR_USER_WR_MASK; // [RL16]
        end
        `PSCR_OFS_OPEN_LOOP:    state_next.open_loop = REG_WDATA; // [RL15]
        default: begin
          state_next.open_loop = state_reg.open_loop;
        end
      endcase
    end
    // Decoded outputs follow the new register values on the same edge
    state_next.ctrl = decode(state_next, LIGHT_CFG_UPPER_SOURCE);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= STATE_RST; // [RL15]
    end else begin
      state_reg <= state_next;
    end
  end

  assign REG_RDATA  = state_reg.rdata;
  assign REG_RVALID = state_reg.rvalid;
  assign CTRL       = state_reg.ctrl;

endmodule : pscr_config_regs

// ---- verif/pscr_config_regs_chk.sv ----
// Port-level assertions for the register bank
`timescale 1ns/100ps
module pscr_chk
  import pscr_pkg::*;
(
  input wire logic          CLK,
  input wire logic          SYS_RST,
  input wire logic [7:0]    REG_ADDR,
  input wire logic          REG_WR,
  input wire logic          REG_RD,
  input wire logic [7:0]    REG_WDATA,
  input wire logic [7:0]    REG_RDATA,
  input wire logic          REG_RVALID,
  input wire logic          LIGHT_CFG_UPPER_SOURCE,
  input wire pscr_ctrl_type CTRL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_RVALID: assert property (REG_RD |=> REG_RVALID ##1 (REG_RVALID == $past(REG_RD)))
    else $error("read answer pulse wrong");
  AST_OFS_TIME: assert property (REG_WR && REG_ADDR == 8'h10 |=> CTRL.offset_rail_stage_time_ms ==
    ($past(REG_WDATA[7:5]) == 3'h0 ? 9'h001 : 9'h005 << ($past(REG_WDATA[7:5]) - 1))) else $error("offset time");
  AST_BIAS_SKIP: assert property (REG_WR && REG_ADDR == 8'h11 |=> CTRL.bias_rail_stage_skip ==
    ($past(REG_WDATA[7:5]) == 3'h0)) else $error("bias stage skip wrong");
  AST_TRIM: assert property (REG_WR && REG_ADDR == 8'h14 |=> CTRL.aux_converter_two_mv ==
    13'(1000 + $past(REG_WDATA) * 1569 / 100)) else $error("trim voltage wrong");
  AST_SKIP: assert property (REG_WR && REG_ADDR == 8'h16 |=> CTRL.skip_enable == $past(REG_WDATA[4:0]))
    else $error("skip enables wrong");
  AST_USER: assert property (REG_WR && REG_ADDR == 8'h17 |=> CTRL.external_lowside_limit_enable ==
    $past(REG_WDATA[5]) && CTRL.serial_clock_range_select == $past(REG_WDATA[7])) else $error("user bits wrong");
  AST_EXT: assert property (REG_WR && REG_ADDR == 8'h17 && REG_WDATA[0] && !LIGHT_CFG_UPPER_SOURCE |=>
    CTRL.light_mode == PSCR_LIGHT_EXTERNAL) else $error("external light mode missing");
  AST_OLV: assert property (REG_WR && REG_ADDR == 8'h18 |=> CTRL.light_open_loop_voltage_v ==
    5'h03 + $past(REG_WDATA[7:4])) else $error("open loop voltage wrong");
  AST_SKIP_RSV: assert property (REG_RD && REG_ADDR == 8'h16 |=> REG_RDATA[7:5] == 3'h0)
    else $error("skip reserved bits read nonzero");
  AST_UNMAPPED: assert property (REG_RD && REG_ADDR == 8'h12 |=> REG_RDATA == 8'h00)
    else $error("unmapped read nonzero");
endmodule : pscr_chk

bind pscr_config_regs pscr_chk pscr_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .LIGHT_CFG_UPPER_SOURCE(LIGHT_CFG_UPPER_SOURCE), .CTRL(CTRL));

// ---- verif/tb_top.sv ----
// Self-checking bench for the register bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top
  import pscr_pkg::*;
;
  logic          clk;
  logic          rst;
  logic [7:0]    addr;
  logic          wr_s;
  logic          rd_s;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          rvalid;
  logic          upper;
  pscr_ctrl_type ctrl;
  int            n_mismatch = 0;
  int            n_compared = 0;
  logic [8:0]    ms [8] = '{9'h001, 9'h005, 9'h00A, 9'h014, 9'h028, 9'h050, 9'h0A0, 9'h140};
  // Upper bit, low nibble, expected mode packed in one byte
  logic [7:0]    lt [10] = '{8'h80, 8'hB1, 8'h92, 8'hD3, 8'h0C, 8'h31, 8'h20, 8'h53, 8'h12, 8'h5C};

  pscr_config_regs pscr_config_regs_i (.CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .LIGHT_CFG_UPPER_SOURCE(upper), .CTRL(ctrl));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(posedge clk);
    #1;
    wr_s = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = a;
    rd_s = 1'b1;
    @(posedge clk);
    #1;
    rd_s = 1'b0;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd

  task automatic final_report;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    wdata = 8'h00;
    upper = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(8'h10, 8'hC0);
    rd(8'h17, 8'h02);
    rd(8'h11, 8'h00);
    `CHK("reset light", PSCR_LIGHT_SINGLE_6A, ctrl.light_mode)
    `CHK("reset trim", 13'h03E8, ctrl.aux_converter_two_mv)
    wr(8'h16, 8'hFF);
    rd(8'h16, 8'h1F);
    wr(8'h16, 8'h08);
    `CHK("skip one", 1'b1, ctrl.skip_enable.aux_converter_one)
    `CHK("skip all", 5'h08, ctrl.skip_enable)
    wr(8'h17, 8'hFF);
    rd(8'h17, 8'hAF);
    `CHK("clock range", 1'b1, ctrl.serial_clock_range_select)
    `CHK("limit", 1'b1, ctrl.external_lowside_limit_enable)
    wr(8'h12, 8'h77);
    rd(8'h12, 8'h00);
    for (logic [3:0] i = 0; i < 8; i++) begin
      wr(8'h10, {i[2:0], 5'h00});
      `CHK("ofs ms", ms[i], ctrl.offset_rail_stage_time_ms)
      `CHK("batt cv", 11'h189, ctrl.battery_warning_threshold_cv)
      `CHK("batt code", 5'h00, ctrl.battery_warning_threshold_code)
      wr(8'h11, {i[2:0], 5'h1F});
      `CHK("bias ms", (i == 0) ? 9'h000 : ms[i], ctrl.bias_rail_stage_time_ms)
      `CHK("uvlo cv", 11'h731, ctrl.lockout_threshold_cv)
      `CHK("uvlo code", 5'h1F, ctrl.lockout_threshold_code)
    end
    rd(8'h11, 8'hFF);
    wr(8'h14, 8'hFF);
    `CHK("trim max", 13'h1388, ctrl.aux_converter_two_mv)
    `CHK("trim code", 8'hFF, ctrl.aux_converter_two_trim)
    wr(8'h18, 8'hF5);
    rd(8'h18, 8'hF5);
    `CHK("olv max", 5'h12, ctrl.light_open_loop_voltage_v)
    `CHK("olv code", 4'hF, ctrl.light_open_loop_voltage_code)
    // Mid-run reset must restore open-loop, trim and offset stage registers and bias stage skip
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(8'h18, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h10, 8'hC0);
    `CHK("rst bias skip", 1'b1, ctrl.bias_rail_stage_skip)
    `CHK("rst ofs ms", 9'h0A0, ctrl.offset_rail_stage_time_ms)
    foreach (lt[k]) begin
      upper = lt[k][7];
      wr(8'h17, {4'h0, lt[k][6:3]});
      `CHK("light", pscr_light_mode_type'(lt[k][2:0]), ctrl.light_mode)
    end
    `CHK("clock range low", 1'b0, ctrl.serial_clock_range_select)
    final_report;
  end
endmodule : tb_top
